// [design/tape_seq_pkg.sv]
package tape_seq_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int START_DELAY_US = 5000;
  localparam int STOP_DELAY_US = 3000;
  localparam int CHAR_PERIOD_NS = 28000;
  localparam int SKEW_DELAY_NS = 8000;
  localparam int CHAR_CYC = CHAR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SKEW_CYC = (SKEW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] CHAR_RELOAD = 11'(CHAR_CYC - 1);
  localparam logic [8:0] SKEW_RELOAD = 9'(SKEW_CYC - 1);
  localparam logic [1:0] EOR_GAP_LAST = 2'h3;

  // register port addresses
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_GO = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;

  // command register layout
  localparam logic [11:0] CMD_RESET = 12'h000;
  localparam int CMD_FUNC_LSB = 0;
  localparam int CMD_NINE_TRACK = 3;
  localparam int CMD_DENS_LSB = 4;
  localparam int CMD_PARITY_ODD = 6;
  localparam int CMD_UNIT_LSB = 7;
  localparam int CMD_IE_DONE = 10;
  localparam int CMD_IE_ERR = 11;
  localparam logic [2:0] FUNC_NOP = 3'h0;
  localparam logic [2:0] FUNC_READ = 3'h1;
  localparam logic [2:0] FUNC_WRITE = 3'h2;
  localparam logic [1:0] DENS_800 = 2'h3;

  // status register layout
  localparam int STAT_ERROR = 0;
  localparam int STAT_ILLEGAL = 3;
  localparam int STAT_PARITY = 4;
  localparam int STAT_LATE = 9;
  localparam int STAT_DONE = 11;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ACCEL = 3'b001,
    S_WRITE = 3'b010,
    S_GAP = 3'b011,
    S_WAIT_EOR = 3'b100,
    S_READ = 3'b101,
    S_DECEL = 3'b110
  } seq_state_t;
endpackage

// [design/tape_interval_timer.sv]
`timescale 1ns/1ps
module tape_interval_timer
  import tape_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [23:0] length,
  output logic busy,
  output logic done
);
  logic [23:0] cnt_q;
  logic busy_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= 24'h000000;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= length;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 24'h000001;
      if (cnt_q == 24'h000001) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == 24'h000001);
endmodule // tape_interval_timer

// [design/tape_seq.sv]
`timescale 1ns/1ps
module tape_seq
  import tape_seq_pkg::*;
#(
  parameter int START_CYC = START_DELAY_US * 1000 / CLK_PERIOD_NS,
  parameter int STOP_CYC = STOP_DELAY_US * 1000 / CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [17:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [17:0] reg_rdata,
  output logic dch_word_req,
  input wire logic dch_ack,
  input wire logic [17:0] dch_wdata,
  output logic [17:0] dch_rdata,
  input wire logic dch_wc_zero,
  output logic irq,
  output logic skip_job_done,
  output logic skip_transport_ready,
  output logic skip_controller_ready,
  output logic skip_error,
  output logic [2:0] tp_unit,
  input wire logic tp_ready,
  output logic tp_move,
  output logic tp_write_enable,
  output logic [8:0] tp_head,
  output logic tp_record,
  input wire logic [8:0] tp_read_pulse,
  input wire logic tp_eor
);
  seq_state_t state_q, state_d;
  logic [11:0] cmd_q, hold_q;
  logic strobe_q, go_q, done_q, illegal_q, parity_q, late_q, word_req_q, last_word_q;
  logic wr_en_q, move_q, record_q;
  logic [17:0] dbuf_q, rd_word_q, dbuf_sh, rdata_q;
  logic [1:0] cc_q, gap_q;
  logic [10:0] tick_q;
  logic [8:0] skew_q, rx_q, wbuf_q, wr_bits;
  logic skew_busy_q;
  logic [7:0] char_d, rx_ch;
  logic [2:0] func;
  logic nine, odd, cmd_legal, err, cmd_wr, go_wr, clear_all, go_ok;
  logic tick, wr_char, late_wr, cc_last, rd_strobe, rd_char, rd_full, late_rd, longitudinal_parity_character;
  logic tmr_start, tmr_done, rx_par;

  assign func = cmd_q[CMD_FUNC_LSB +: 3];
  assign nine = cmd_q[CMD_NINE_TRACK];
  assign odd = cmd_q[CMD_PARITY_ODD];
  assign tp_unit = cmd_q[CMD_UNIT_LSB +: 3];
  assign err = illegal_q | parity_q | late_q;

  // legality settles from the command register alone, ahead of go
  assign cmd_legal = ((func == FUNC_READ) || (func == FUNC_WRITE))
                     && (!nine || (cmd_q[CMD_DENS_LSB +: 2] == DENS_800));
  assign cmd_wr = reg_wr && (reg_addr == ADDR_CMD);
  assign go_wr = reg_wr && (reg_addr == ADDR_GO);
  assign clear_all = cmd_wr && !go_q;
  assign go_ok = go_wr && !go_q && cmd_legal && tp_ready && !strobe_q;

  // command register: clear pulse first, strobe of the held word next cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmd_q <= CMD_RESET;
      hold_q <= CMD_RESET;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= clear_all;
      if (clear_all) begin
        hold_q <= reg_wdata[11:0];
      end
      if (strobe_q) begin
        cmd_q <= hold_q;
      end else if (clear_all) begin
        cmd_q <= CMD_RESET;
      end
    end
  end

  // flags: set wins over the clear-all pulse
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      illegal_q <= 1'b0;
      parity_q <= 1'b0;
      late_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (clear_all) begin
        illegal_q <= 1'b0;
        parity_q <= 1'b0;
        late_q <= 1'b0;
        done_q <= 1'b0;
      end
      if ((cmd_wr && go_q && !done_q) || (go_wr && !go_q && !go_ok)) begin
        illegal_q <= 1'b1;
      end
      if (rd_char && ((^rx_ch ^ odd) != rx_par)) begin
        parity_q <= 1'b1;
      end
      if (late_wr || late_rd) begin
        late_q <= 1'b1;
      end
      if (tmr_start && (state_q != S_IDLE)) begin
        done_q <= 1'b1;
      end
    end
  end

  // go holds for the whole operation, ends with the deceleration delay
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      go_q <= 1'b0;
    end else if (go_ok) begin
      go_q <= 1'b1;
    end else if ((state_q == S_DECEL) && tmr_done) begin
      go_q <= 1'b0;
    end
  end

  assign tmr_start = go_ok || ((state_q != S_DECEL) && (state_d == S_DECEL));

  tape_interval_timer u_gap_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(tmr_start),
    .length(go_ok ? 24'(START_CYC) : 24'(STOP_CYC)),
    .busy(),
    .done(tmr_done)
  );

  // character clock for writing
  assign tick = ((state_q == S_WRITE) || (state_q == S_GAP)) && (tick_q == 11'h000);
  always_ff @(posedge clk_sys) begin
    if (sys_rst || tick || !((state_q == S_WRITE) || (state_q == S_GAP))) begin
      tick_q <= CHAR_RELOAD;
    end else begin
      tick_q <= tick_q - 11'h001;
    end
  end

  assign cc_last = nine ? (cc_q == 2'h1) : (cc_q == 2'h2);
  assign wr_char = (state_q == S_WRITE) && tick && !word_req_q;
  assign late_wr = (state_q == S_WRITE) && tick && word_req_q;
  assign longitudinal_parity_character = (state_q == S_GAP) && tick && (gap_q == EOR_GAP_LAST);

  // character select, high-order character first
  always_comb begin
    char_d = 8'h00;
    if (nine) begin
      char_d = (cc_q == 2'h0) ? dbuf_q[17:10] : dbuf_q[9:2];
    end else begin
      case (cc_q)
        2'h0: char_d = {2'h0, dbuf_q[17:12]};
        2'h1: char_d = {2'h0, dbuf_q[11:6]};
        default: char_d = {2'h0, dbuf_q[5:0]};
      endcase
    end
    wr_bits = nine ? {^char_d ^ odd, char_d} : {2'h0, ^char_d ^ odd, char_d[5:0]};
  end

  // write buffer, one NRZ flip-flop per channel
  genvar ch;
  generate
    for (ch = 0; ch < 9; ch++) begin : g_wbuf
      always_ff @(posedge clk_sys) begin
        if (sys_rst || clear_all || longitudinal_parity_character) begin
          wbuf_q[ch] <= 1'b0;
        end else if (wr_char && wr_en_q && wr_bits[ch]) begin
          wbuf_q[ch] <= ~wbuf_q[ch];
        end
      end
    end
  endgenerate

  // read side: skew window opened by the first transition
  assign rd_strobe = skew_busy_q && (skew_q == 9'h000);
  assign rd_char = rd_strobe && (state_q == S_READ);
  assign rd_full = rd_char && cc_last;
  assign late_rd = rd_full && word_req_q;
  assign rx_ch = nine ? rx_q[7:0] : {2'h0, rx_q[5:0]};
  assign rx_par = nine ? rx_q[8] : rx_q[6];
  assign dbuf_sh = nine ? {dbuf_q[9:2], rx_ch, 2'h0} : {dbuf_q[11:0], rx_ch[5:0]};

  always_ff @(posedge clk_sys) begin
    if (sys_rst || (state_q != S_READ)) begin
      skew_busy_q <= 1'b0;
      skew_q <= SKEW_RELOAD;
      rx_q <= 9'h000;
    end else if (rd_strobe) begin
      skew_busy_q <= 1'b0;
      rx_q <= 9'h000;
    end else if (skew_busy_q) begin
      skew_q <= skew_q - 9'h001;
      rx_q <= rx_q | tp_read_pulse;
    end else if (|tp_read_pulse) begin
      skew_busy_q <= 1'b1;
      skew_q <= SKEW_RELOAD;
      rx_q <= tp_read_pulse;
    end
  end

  // data buffer and character counter
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear_all) begin
      dbuf_q <= 18'h00000;
      rd_word_q <= 18'h00000;
      cc_q <= 2'h0;
    end else begin
      if (go_ok) begin
        cc_q <= 2'h0;
      end else if (wr_char || rd_char) begin
        cc_q <= cc_last ? 2'h0 : cc_q + 2'h1;
      end
      if (dch_ack && (func == FUNC_WRITE)) begin
        dbuf_q <= dch_wdata;
      end else if (rd_char) begin
        dbuf_q <= dbuf_sh;
      end
      if (rd_full) begin
        rd_word_q <= dbuf_sh;
      end
    end
  end

  // word request to the data channel; a new request wins over an ack
  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear_all) begin
      word_req_q <= 1'b0;
      last_word_q <= 1'b0;
    end else begin
      if (go_ok) begin
        last_word_q <= 1'b0;
      end else if (dch_wc_zero) begin
        last_word_q <= 1'b1;
      end
      if ((go_ok && (func == FUNC_WRITE))
          || (wr_char && cc_last && !last_word_q)
          || (rd_full && (state_d == S_READ))) begin
        word_req_q <= 1'b1;
      end else if (dch_ack) begin
        word_req_q <= 1'b0;
      end
    end
  end

  // operation sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (go_ok) state_d = S_ACCEL;
      S_ACCEL: if (tmr_done) state_d = (func == FUNC_WRITE) ? S_WRITE : S_READ;
      S_WRITE: if (late_wr || (wr_char && cc_last && last_word_q)) state_d = S_GAP;
      S_GAP: if (longitudinal_parity_character) state_d = S_WAIT_EOR;
      S_WAIT_EOR: if (tp_eor) state_d = S_DECEL;
      S_READ: begin
        if (tp_eor) begin
          state_d = S_DECEL;
        end else if (late_rd) begin
          state_d = S_WAIT_EOR;
        end
      end
      S_DECEL: if (tmr_done) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      gap_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q != S_GAP) begin
        gap_q <= 2'h0;
      end else if (tick) begin
        gap_q <= gap_q + 2'h1;
      end
    end
  end

  // transport drive
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_en_q <= 1'b0;
      move_q <= 1'b0;
      record_q <= 1'b0;
    end else begin
      wr_en_q <= (state_d == S_WRITE) || (state_d == S_GAP) || longitudinal_parity_character;
      move_q <= (state_d != S_IDLE) && (state_d != S_DECEL);
      record_q <= (wr_char && wr_en_q) || longitudinal_parity_character;
    end
  end

  assign tp_write_enable = wr_en_q;
  assign tp_move = move_q;
  assign tp_record = record_q;
  assign tp_head = wbuf_q;
  assign dch_word_req = word_req_q;
  assign dch_rdata = rd_word_q;

  // register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !reg_rd) begin
      rdata_q <= 18'h00000;
    end else begin
      case (reg_addr)
        ADDR_CMD: rdata_q <= {6'h00, cmd_q};
        ADDR_STATUS: begin
          rdata_q <= 18'h00000;
          rdata_q[STAT_ERROR] <= err;
          rdata_q[STAT_ILLEGAL] <= illegal_q;
          rdata_q[STAT_PARITY] <= parity_q;
          rdata_q[STAT_LATE] <= late_q;
          rdata_q[STAT_DONE] <= done_q;
        end
        default: rdata_q <= 18'h00000;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  assign irq = (done_q && cmd_q[CMD_IE_DONE]) || (err && cmd_q[CMD_IE_ERR]);
  assign skip_job_done = done_q;
  assign skip_transport_ready = tp_ready;
  assign skip_controller_ready = !go_q;
  assign skip_error = err;

  property p_load_cmd;
    @(posedge clk_sys) disable iff (sys_rst)
    clear_all |=> !done_q && !err ##1 cmd_q == $past(reg_wdata[11:0], 2);
  endproperty
  a_load_cmd: assert property (p_load_cmd) else $error("command load sequence wrong");

  property p_go_gate;
    @(posedge clk_sys) disable iff (sys_rst)
    go_wr && !go_q && !(cmd_legal && tp_ready && !strobe_q) |=> !go_q && illegal_q;
  endproperty
  a_go_gate: assert property (p_go_gate) else $error("illegal go was accepted");

  property p_start;
    @(posedge clk_sys) disable iff (sys_rst)
    go_ok |=> tp_move && (state_q == S_ACCEL) && !tp_write_enable && go_q;
  endproperty
  a_start: assert property (p_start) else $error("go did not start motion");

  property p_first_req;
    @(posedge clk_sys) disable iff (sys_rst)
    go_ok && (func == FUNC_WRITE) |=> dch_word_req ##1 (dch_word_req || $past(dch_ack));
  endproperty
  a_first_req: assert property (p_first_req) else $error("no word request in start delay");

  property p_split;
    @(posedge clk_sys) disable iff (sys_rst)
    wr_char && !nine && (cc_q == 2'h0)
      |=> tp_head[5:0] == ($past(tp_head[5:0]) ^ $past(dbuf_q[17:12])) && tp_record;
  endproperty
  a_split: assert property (p_split) else $error("first character not high order");

  property p_next_req;
    @(posedge clk_sys) disable iff (sys_rst)
    wr_char && cc_last && !last_word_q |=> dch_word_req && (cc_q == 2'h0);
  endproperty
  a_next_req: assert property (p_next_req) else $error("next word not requested");

  property p_longitudinal_parity_character;
    @(posedge clk_sys) disable iff (sys_rst)
    longitudinal_parity_character |=> (tp_head == 9'h000) && tp_record && tp_write_enable ##1 !tp_write_enable;
  endproperty
  a_longitudinal_parity_character: assert property (p_longitudinal_parity_character) else $error("parity character not written");

  property p_no_drive;
    @(posedge clk_sys) disable iff (sys_rst)
    !tp_write_enable && (state_q != S_GAP) && !clear_all |=> $stable(tp_head);
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("head toggled without enable");

  property p_eor_stop;
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == S_WAIT_EOR) && tp_eor |=> done_q && !tp_move && go_q;
  endproperty
  a_eor_stop: assert property (p_eor_stop) else $error("end of record not handled");

  property p_skew;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(skew_busy_q) |-> !rd_strobe [*8];
  endproperty
  a_skew: assert property (p_skew) else $error("strobe before skew delay");

  property p_read_full;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_full && !tp_eor |=> dch_word_req && (dch_rdata == $past(dbuf_sh));
  endproperty
  a_read_full: assert property (p_read_full) else $error("full word not offered");

  property p_go_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    go_q && (state_q != S_DECEL) |=> go_q && !skip_controller_ready;
  endproperty
  a_go_hold: assert property (p_go_hold) else $error("go dropped early");
endmodule // tape_seq

// [bench/tape_far_model.sv]
`timescale 1ns/1ps
module tape_far_model (
  input wire logic clk_sys,
  input wire logic [2:0] tp_unit,
  output logic tp_ready,
  input wire logic tp_move,
  input wire logic tp_write_enable,
  output logic [8:0] tp_read_pulse,
  output logic tp_eor,
  input wire logic dch_word_req,
  output logic dch_ack,
  output logic [17:0] dch_wdata,
  output logic dch_wc_zero,
  input wire logic [35:0] mem_words,
  input wire logic [1:0] n_words,
  input wire logic rd_start,
  input wire logic [17:0] rd_word
);
  int idx = 0;
  logic [5:0] ch;
  logic [6:0] bits;

  // unit 7 is absent
  assign tp_ready = (tp_unit != 3'h7);

  initial begin
    dch_ack = 1'b0;
    dch_wc_zero = 1'b0;
    dch_wdata = 18'h0;
    tp_eor = 1'b0;
    tp_read_pulse = 9'h0;
  end

  // data channel: first word fast, later words slow
  always begin
    @(posedge clk_sys);
    if (!tp_move) idx = 0;
    if (dch_word_req) begin
      repeat (3 + 150 * idx) @(posedge clk_sys);
      dch_wdata <= mem_words[35 - 18 * idx -: 18];
      dch_wc_zero <= (idx == int'(n_words) - 1);
      dch_ack <= 1'b1;
      @(posedge clk_sys);
      dch_ack <= 1'b0;
      dch_wc_zero <= 1'b0;
      dch_wdata <= ~dch_wdata;
      idx = idx + 1;
    end
  end

  // read head sees end of record some time after writing stops
  always @(negedge tp_write_enable) begin
    if (tp_move === 1'b1) begin
      repeat (200) @(posedge clk_sys);
      tp_eor <= 1'b1;
      @(posedge clk_sys);
      tp_eor <= 1'b0;
    end
  end

  // playback of one 7-track word, channel 0 arriving skewed
  always @(posedge rd_start) begin
    for (int c = 0; c < 3; c++) begin
      ch = rd_word[17 - 6 * c -: 6];
      bits = {~^ch, ch};
      repeat (1000) @(posedge clk_sys);
      tp_read_pulse <= {2'b00, bits & 7'h7e};
      @(posedge clk_sys);
      tp_read_pulse <= 9'h0;
      repeat (100) @(posedge clk_sys);
      tp_read_pulse <= {8'h00, bits[0]};
      @(posedge clk_sys);
      tp_read_pulse <= 9'h0;
    end
    repeat (1000) @(posedge clk_sys);
    tp_eor <= 1'b1;
    @(posedge clk_sys);
    tp_eor <= 1'b0;
  end
endmodule // tape_far_model

// [bench/tape_seq_tb.sv]
`timescale 1ns/1ps
module tape_seq_tb;
  import tape_seq_pkg::*;
  logic clk_sys, sys_rst, reg_wr, reg_rd, dch_word_req, dch_ack, dch_wc_zero, irq;
  logic skip_job_done, skip_transport_ready, skip_controller_ready, skip_error;
  logic tp_ready, tp_move, tp_write_enable, tp_record, tp_eor, rd_start;
  logic [1:0] reg_addr, n_words;
  logic [17:0] reg_wdata, reg_rdata, dch_wdata, dch_rdata, rd_word;
  logic [2:0] tp_unit;
  logic [8:0] tp_head, tp_read_pulse;
  logic [35:0] mem_words;
  int mismatches = 0;
  int n_checks = 0;
  logic [17:0] exp_reg[$];
  logic [8:0] exp_head[$];
  logic [17:0] exp_word[$];
  logic rd_seen = 1'b0;
  logic req_q = 1'b0;
  logic rd_mode = 1'b0;

  tape_seq #(.START_CYC(20), .STOP_CYC(10)) DUT (.clk_sys, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dch_word_req, .dch_ack, .dch_wdata,
    .dch_rdata, .dch_wc_zero, .irq, .skip_job_done, .skip_transport_ready,
    .skip_controller_ready, .skip_error, .tp_unit, .tp_ready, .tp_move,
    .tp_write_enable, .tp_head, .tp_record, .tp_read_pulse, .tp_eor);

  tape_far_model u_far (.clk_sys, .tp_unit, .tp_ready, .tp_move, .tp_write_enable,
    .tp_read_pulse, .tp_eor, .dch_word_req, .dch_ack, .dch_wdata, .dch_wc_zero,
    .mem_words, .n_words, .rd_start, .rd_word);

  task automatic chk(string nm, logic [17:0] e, logic [17:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(logic [1:0] a, logic [17:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [1:0] a, logic [17:0] e);
    exp_reg.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
  endtask

  // wait for job done, then check stop and release of the controller
  task automatic finish(logic [11:0] cmd);
    int n = 0;
    while (skip_job_done !== 1'b1 && n < 30000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("done_wait", 18'h0, 18'(n == 30000));
    chk("tp_move", 18'h0, 18'(tp_move));
    chk("ctrl_ready", 18'h0, 18'(skip_controller_ready));
    chk("irq", 18'(cmd[10]), 18'(irq));
    repeat (12) @(posedge clk_sys);
    #1;
    chk("ctrl_ready", 18'h1, 18'(skip_controller_ready));
    rd(ADDR_STATUS, 18'h800);
  endtask

  always @(posedge clk_sys) begin
    if (rd_seen) chk("reg_rdata", exp_reg.pop_front(), reg_rdata);
    if (tp_record) chk("tp_head", 18'(exp_head.pop_front()), 18'(tp_head));
    if (rd_mode && dch_word_req && !req_q) chk("dch_rdata", exp_word.pop_front(), dch_rdata);
    rd_seen <= reg_rd;
    req_q <= dch_word_req;
  end

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end

  initial begin
    logic [17:0] w[2];
    logic [11:0] cmd;
    logic [8:0] h;
    logic [7:0] c8;
    logic [5:0] c6;
    sys_rst = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 18'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mem_words = 36'h0;
    n_words = 2'h2;
    rd_start = 1'b0;
    rd_word = 18'h0;
    void'($urandom(37));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("ctrl_ready", 18'h1, 18'(skip_controller_ready));
    chk("tp_head", 18'h0, 18'(tp_head));
    rd(ADDR_STATUS, 18'h0);
    // nop on absent unit 7, error interrupt enabled
    wr(ADDR_CMD, 18'h0b80);
    rd(ADDR_CMD, 18'h0b80);
    chk("tp_unit", 18'h7, 18'(tp_unit));
    chk("tp_ready", 18'h0, 18'(skip_transport_ready));
    wr(ADDR_GO, 18'h0);
    rd(ADDR_STATUS, 18'h009);
    chk("ctrl_ready", 18'h1, 18'(skip_controller_ready));
    chk("irq", 18'h1, 18'(irq));
    chk("error", 18'h1, 18'(skip_error));
    // nine-track write at a density other than 800 is refused
    wr(ADDR_CMD, 18'h00a);
    wr(ADDR_GO, 18'h0);
    rd(ADDR_STATUS, 18'h009);
    chk("ctrl_ready", 18'h1, 18'(skip_controller_ready));
    for (int nine = 0; nine < 2; nine++) begin
      w[0] = 18'($urandom);
      w[1] = 18'($urandom);
      mem_words <= {w[0], w[1]};
      cmd = 12'h442 | (nine == 1 ? 12'h038 : 12'h000);
      h = 9'h0;
      for (int k = 0; k < 6 - 2 * nine; k++) begin
        c8 = w[k / 2][17 - 8 * (k % 2) -: 8];
        c6 = w[k / 3][17 - 6 * (k % 3) -: 6];
        h ^= (nine == 1) ? {~^c8, c8} : {2'b00, ~^c6, c6};
        exp_head.push_back(h);
      end
      exp_head.push_back(9'h0);
      chk("ctrl_ready", 18'h1, 18'(skip_controller_ready));
      wr(ADDR_CMD, 18'(cmd));
      chk("tp_ready", 18'h1, 18'(skip_transport_ready));
      wr(ADDR_GO, 18'h0);
      @(posedge clk_sys);
      #1;
      chk("tp_move", 18'h1, 18'(tp_move));
      chk("word_req", 18'h1, 18'(dch_word_req));
      chk("ctrl_ready", 18'h0, 18'(skip_controller_ready));
      chk("write_en", 18'h0, 18'(tp_write_enable));
      finish(cmd);
      chk("chars_left", 18'h0, 18'(exp_head.size()));
    end
    // read one word with skewed channel, done interrupt masked
    rd_mode = 1'b1;
    w[0] = 18'($urandom);
    exp_word.push_back(w[0]);
    rd_word <= w[0];
    cmd = 12'h041;
    wr(ADDR_CMD, 18'(cmd));
    wr(ADDR_GO, 18'h0);
    repeat (25) @(posedge clk_sys);
    rd_start <= 1'b1;
    @(posedge clk_sys);
    rd_start <= 1'b0;
    finish(cmd);
    chk("words_left", 18'h0, 18'(exp_word.size()));
    end_sim();
  end
endmodule // tape_seq_tb
